// ==== logic/pvsir_regs.sv ====
// vendor status, loopback and interrupt registers behind a management slave
// frame handling
//   mdc and mdio pass two flops; a third flop finds the mdc rise
//   mdc must stay high and low at least four clk each
//   32 ones then a start zero open a frame
//   no preamble suppression: every frame needs its own
//   wrong start, op or address: frame ignored, line never driven
//   read data latched as the register address completes
//   turnaround bit two driven low, then data msb first
//   line released after the rise that samples data bit 0
//   write lands in the same clk as the rise sampling data bit 0
// register notes
//   unmapped addresses and cable diagnostics read zero
//   read-only bits and bit 0 of the loopback register drop writes
//   reserved loopback bits are stored and read back
//   polarity bit alone is kept in the control register
// hazards
//   read-clear acts on the value just returned
//   a pulse in the read-clear clk is kept: set wins
//   counter saturates rather than wrapping to zero
//   flags set whatever the enables; enables only gate the pin
//   interrupt pin lags an event by two clk
`timescale 1ns/1ps
`default_nettype none
module pvsir_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   mdc,
  input  wire logic                   mdio_i,
  output logic                        mdio_o,
  output logic                        mdio_oe,
  input  wire pvsir_pkg::pvsir_evt_s  evt,
  input  wire pvsir_pkg::pvsir_link_s link,
  input  wire logic                   symbol_error_frames,
  output logic                        remote_loopback,
  output logic                        led_test,
  output logic                        int_pin
);

  // synchroniser and edge flops
  logic                   mdc_s1_q;
  logic                   mdc_s2_q;
  logic                   mdc_s3_q;
  logic                   mdio_s1_q;
  logic                   mdio_s2_q;
  logic                   rise;
  // frame decoder state
  pvsir_pkg::pvsir_state_e state_q;
  logic [5:0]             ones_q;
  logic [3:0]             cnt_q;
  logic [12:0]            hdr_q;
  logic [13:0]            hdr;
  logic [4:0]             reg_q;
  logic                   is_rd_q;
  logic [15:0]            data_q;
  logic [15:0]            rd_word;
  logic                   hdr_done;
  logic                   hdr_ok;
  logic                   rd_take;
  logic                   wr_take;
  logic [15:0]            wr_word;
  // register storage
  logic [15:0]            lb_led_q;
  logic [7:0]             int_en_q;
  logic [7:0]             int_flag_q;
  logic [15:0]            symerr_q;
  logic                   pol_q;
  pvsir_pkg::pvsir_link_s link_q;

  // two-stage synchronisers for the management pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mdc_s1_q  <= 1'b0;
      mdc_s2_q  <= 1'b0;
      mdc_s3_q  <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdc_s1_q  <= mdc;
      mdc_s2_q  <= mdc_s1_q;
      mdc_s3_q  <= mdc_s2_q;
      mdio_s1_q <= mdio_i;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  // frame decode helpers
  assign rise     = mdc_s2_q & ~mdc_s3_q;
  assign hdr      = {hdr_q, mdio_s2_q};
  assign hdr_done = rise && (state_q == pvsir_pkg::S_HDR)
                    && (cnt_q == pvsir_pkg::HDR_LAST);
  assign hdr_ok   = (hdr[13:12] == pvsir_pkg::ST_CODE)
                    && (hdr[9:5] == PHY_ADDR)
                    && ((hdr[11:10] == pvsir_pkg::OP_RD)
                        || (hdr[11:10] == pvsir_pkg::OP_WR));
  assign rd_take  = hdr_done && hdr_ok && (hdr[11:10] == pvsir_pkg::OP_RD);
  assign wr_take  = rise && (state_q == pvsir_pkg::S_WR)
                    && (cnt_q == pvsir_pkg::DATA_LAST);
  assign wr_word  = {data_q[14:0], mdio_s2_q};

  // read data mux, sampled when the header completes
  always_comb begin
    rd_word = 16'h0000;
    case (hdr[4:0])
      pvsir_pkg::REG_LB_LED: rd_word = lb_led_q;
      pvsir_pkg::REG_LINK: begin
        rd_word[pvsir_pkg::LINK1000_BIT] = link_q.link_1000;
        rd_word[pvsir_pkg::LINK100_BIT]  = link_q.link_100;
      end
      pvsir_pkg::REG_SYMERR: rd_word = symerr_q;
      pvsir_pkg::REG_INT:    rd_word = {int_en_q, int_flag_q};
      pvsir_pkg::REG_PHYCTL: rd_word[pvsir_pkg::POL_BIT] = pol_q;
      default:               rd_word = 16'h0000;
    endcase
  end

  // management frame state machine and serial data driver
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= pvsir_pkg::S_PRE;
      ones_q  <= 6'd0;
      cnt_q   <= 4'd0;
      hdr_q   <= 13'h0000;
      reg_q   <= 5'h00;
      is_rd_q <= 1'b0;
      data_q  <= 16'h0000;
      mdio_o  <= 1'b1;
      mdio_oe <= 1'b0;
    end else if (rise) begin
      unique case (state_q)
        // wait for 32 ones then a start zero
        pvsir_pkg::S_PRE: begin
          if (mdio_s2_q) begin
            if (ones_q != pvsir_pkg::PRE_LEN) ones_q <= ones_q + 6'd1;
          end else if (ones_q == pvsir_pkg::PRE_LEN) begin
            state_q <= pvsir_pkg::S_HDR; // start bit zero seen
            cnt_q   <= 4'd1;
            hdr_q   <= 13'h0000;
          end else begin
            ones_q <= 6'd0;
          end
        end
        // shift start, op and both addresses
        pvsir_pkg::S_HDR: begin
          hdr_q <= hdr[12:0];
          cnt_q <= cnt_q + 4'd1;
          if (hdr_done) begin
            ones_q <= 6'd0;
            cnt_q  <= 4'd0;
            reg_q  <= hdr[4:0];
            is_rd_q <= (hdr[11:10] == pvsir_pkg::OP_RD);
            data_q  <= rd_word;
            state_q <= hdr_ok ? pvsir_pkg::S_TA : pvsir_pkg::S_PRE;
          end
        end
        // turnaround: take the line on reads
        pvsir_pkg::S_TA: begin
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == 4'd0) begin
            if (is_rd_q) begin
              mdio_oe <= 1'b1; // second turnaround bit driven low
              mdio_o  <= 1'b0;
            end
          end else begin
            cnt_q <= 4'd0;
            if (is_rd_q) begin
              mdio_o  <= data_q[15];
              data_q  <= {data_q[14:0], 1'b0};
              state_q <= pvsir_pkg::S_RD;
            end else begin
              state_q <= pvsir_pkg::S_WR;
            end
          end
        end
        // read data out, msb first
        pvsir_pkg::S_RD: begin
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == pvsir_pkg::DATA_LAST) begin
            mdio_oe <= 1'b0; // release after last bit sampled
            mdio_o  <= 1'b1;
            state_q <= pvsir_pkg::S_PRE;
          end else begin
            mdio_o <= data_q[15];
            data_q <= {data_q[14:0], 1'b0};
          end
        end
        // write data in, msb first
        pvsir_pkg::S_WR: begin
          cnt_q  <= cnt_q + 4'd1;
          data_q <= wr_word;
          if (cnt_q == pvsir_pkg::DATA_LAST) state_q <= pvsir_pkg::S_PRE;
        end
      endcase
    end
  end

  // loopback and LED test control with its reserved read-write bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lb_led_q <= pvsir_pkg::LB_LED_RST;
    end else if (wr_take && reg_q == pvsir_pkg::REG_LB_LED) begin
      lb_led_q <= wr_word & pvsir_pkg::LB_LED_WMASK;
    end
  end

  // loopback and LED test drive the datapath from flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remote_loopback <= 1'b0;
      led_test        <= 1'b0;
    end else begin
      remote_loopback <= lb_led_q[pvsir_pkg::LB_BIT];
      led_test        <= lb_led_q[pvsir_pkg::LEDTEST_BIT];
    end
  end

  // link status capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_q <= '0;
    end else begin
      link_q <= link;
    end
  end

  // symbol error frame counter, saturating, cleared on read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      symerr_q <= pvsir_pkg::SYMERR_RST;
    end else if (rd_take && hdr[4:0] == pvsir_pkg::REG_SYMERR) begin
      symerr_q <= {15'h0000, symbol_error_frames};
    end else if (symbol_error_frames
                 && symerr_q != pvsir_pkg::SYMERR_MAX) begin
      symerr_q <= symerr_q + 16'h0001;
    end
  end

  // interrupt enables, written as the upper byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_en_q <= pvsir_pkg::INT_EN_RST;
    end else if (wr_take && reg_q == pvsir_pkg::REG_INT) begin
      int_en_q <= wr_word[15:pvsir_pkg::INT_EN_LSB];
    end
  end

  // sticky event flags: read clears, a same-cycle event wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_flag_q <= pvsir_pkg::INT_FLAG_RST;
    end else if (rd_take && hdr[4:0] == pvsir_pkg::REG_INT) begin
      int_flag_q <= evt;
    end else begin
      int_flag_q <= int_flag_q | evt;
    end
  end

  // interrupt polarity control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pol_q <= pvsir_pkg::POL_RST;
    end else if (wr_take && reg_q == pvsir_pkg::REG_PHYCTL) begin
      pol_q <= wr_word[pvsir_pkg::POL_BIT];
    end
  end

  // interrupt pin: any enabled flag, then polarity
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_pin <= ~pvsir_pkg::POL_RST;
    end else begin
      int_pin <= (|(int_flag_q & int_en_q)) ~^ pol_q;
    end
  end

endmodule
`default_nettype wire

// ==== logic/pvsir_pkg.sv ====
// package: register map, field positions and types of the vendor register bank
`default_nettype none
package pvsir_pkg;
  // register addresses on the management bus
  localparam logic [4:0]  REG_LB_LED    = 5'h11;
  localparam logic [4:0]  REG_CABLE     = 5'h12;
  localparam logic [4:0]  REG_LINK      = 5'h13;
  localparam logic [4:0]  REG_SYMERR    = 5'h15;
  localparam logic [4:0]  REG_INT       = 5'h1B;
  localparam logic [4:0]  REG_PHYCTL    = 5'h1F;
  // field positions
  localparam int          LB_BIT        = 8;
  localparam int          LEDTEST_BIT   = 3;
  localparam int          LINK1000_BIT  = 2;
  localparam int          LINK100_BIT   = 1;
  localparam int          POL_BIT       = 14;
  localparam int          INT_EN_LSB    = 8;
  // reset values and write masks
  localparam logic [15:0] LB_LED_RST    = 16'h02F0;
  localparam logic [15:0] LB_LED_WMASK  = 16'hFFFE;
  localparam logic [7:0]  INT_EN_RST    = 8'h00;
  localparam logic [7:0]  INT_FLAG_RST  = 8'h00;
  localparam logic [15:0] SYMERR_RST    = 16'h0000;
  localparam logic [15:0] SYMERR_MAX    = 16'hFFFF;
  localparam logic        POL_RST       = 1'b0;
  // management frame layout
  localparam logic [5:0]  PRE_LEN       = 6'h20;
  localparam logic [3:0]  HDR_LAST      = 4'hD;
  localparam logic [3:0]  DATA_LAST     = 4'hF;
  localparam logic [1:0]  ST_CODE       = 2'h1;
  localparam logic [1:0]  OP_RD         = 2'h2;
  localparam logic [1:0]  OP_WR         = 2'h1;

  // event strobes, ordered as flag bits 7 down to 0
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_rx;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } pvsir_evt_s;

  // per-speed link status levels
  typedef struct packed {
    logic link_1000;
    logic link_100;
  } pvsir_link_s;

  typedef enum logic [4:0] {
    S_PRE = 5'h01,
    S_HDR = 5'h02,
    S_TA  = 5'h04,
    S_RD  = 5'h08,
    S_WR  = 5'h10
  } pvsir_state_e;
endpackage
`default_nettype wire

// ==== bench/pvsir_regs_assertions.sv ====
// checker for the vendor register bank ports
`timescale 1ns/1ps
`default_nettype none
module pvsir_regs_assertions (
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 mdc,
  input wire logic                 mdio_o,
  input wire logic                 mdio_oe,
  input wire pvsir_pkg::pvsir_evt_s evt,
  input wire logic                 remote_loopback,
  input wire logic                 led_test,
  input wire logic                 int_pin
);
  logic       mdc_q;
  logic [3:0] idle_q;
  // cycles since mdc last moved, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mdc_q  <= 1'b0;
      idle_q <= 4'hF;
    end else begin
      mdc_q  <= mdc;
      idle_q <= (mdc != mdc_q) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hF};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  rst_state_a: assert property ($rose(resetn) |-> !mdio_oe && int_pin
    && !led_test && !remote_loopback) else $error("bad state after reset");
  released_high_a: assert property (!mdio_oe |-> mdio_o)
    else $error("released data line not high");
  ta_low_a: assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround bit not low");
  drive_hold_a: assert property ($rose(mdio_oe) |-> mdio_oe[*8])
    else $error("read drive too short");
  oe_edge_a: assert property ($changed(mdio_oe) |-> idle_q < 4'h8)
    else $error("data drive moved without mdc");
  loop_change_a: assert property ($changed(remote_loopback)
    |-> !mdio_oe && idle_q < 4'h8) else $error("loopback moved alone");
  led_change_a: assert property ($changed(led_test)
    |-> !mdio_oe && idle_q < 4'h8) else $error("led test moved alone");
  int_cause_a: assert property ($changed(int_pin) |-> idle_q < 4'h8
    || $past(evt, 2) != 8'h00 || $past(evt, 3) != 8'h00)
    else $error("interrupt moved without cause");
  cover property ($rose(mdio_oe));
  cover property ($fell(int_pin));
  cover property ($rose(remote_loopback));
endmodule
bind pvsir_regs pvsir_regs_assertions u_pvsir_regs_assertions (
  .clk(clk), .resetn(resetn), .mdc(mdc), .mdio_o(mdio_o),
  .mdio_oe(mdio_oe), .evt(evt), .remote_loopback(remote_loopback),
  .led_test(led_test), .int_pin(int_pin));
`default_nettype wire

// ==== bench/pvsir_mgmt_model.sv ====
// management station model driving mdc and mdio frames
`timescale 1ns/1ps
`default_nettype none
module pvsir_mgmt_model (
  input  wire logic clk,
  input  wire logic mdio,
  output logic      mdc,
  output logic      drv,
  output logic      drv_en
);
  logic smp;
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    drv_en = 1'b0;
  end
  // one mdc period: data set while low, line sampled before the rise
  task automatic bit_cyc(input logic b, input logic en, output logic s);
    @(posedge clk);
    mdc <= 1'b0;
    drv <= b;
    drv_en <= en;
    repeat (5) @(posedge clk);
    s = mdio;
    mdc <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // full frame with fresh preamble; line released from turnaround on reads
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      bit_cyc(f[i], !(op == pvsir_pkg::OP_RD && i < 18), smp);
      if (i < 16) rd[i] = smp;
    end
    @(posedge clk);
    mdc <= 1'b0;
    drv_en <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/pvsir_regs_test.sv ====
// testbench for the vendor register bank over the management bus
`timescale 1ns/1ps
`default_nettype none
module pvsir_regs_test;
  logic clk = 1'b0;
  logic resetn, mdc, drv, drv_en, mdio_o, mdio_oe, mdio_w;
  logic sym, remote_loopback, led_test, int_pin;
  logic [15:0] rd;
  pvsir_pkg::pvsir_evt_s  evt;
  pvsir_pkg::pvsir_link_s link;
  int failures, samples_checked;
  // shared data line with pull-up
  assign mdio_w = mdio_oe ? mdio_o : (drv_en ? drv : 1'b1);
  always #5 clk = ~clk;
  pvsir_regs u_pvsir_regs (.clk(clk), .resetn(resetn), .mdc(mdc),
    .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .evt(evt),
    .link(link), .symbol_error_frames(sym),
    .remote_loopback(remote_loopback), .led_test(led_test),
    .int_pin(int_pin));
  pvsir_mgmt_model u_pvsir_mgmt_model (.clk(clk), .mdio(mdio_w),
    .mdc(mdc), .drv(drv), .drv_en(drv_en));
  task automatic stop_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic pin_chk(input logic e);
    chk("int_pin", {15'h0000, e}, {15'h0000, int_pin});
  endtask
  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e);
    u_pvsir_mgmt_model.frame(pvsir_pkg::OP_RD, 5'h01, ra, 16'h0000, rd);
    chk("read data", e, rd);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    u_pvsir_mgmt_model.frame(pvsir_pkg::OP_WR, 5'h01, ra, wd, rd);
  endtask
  task automatic pulse(input logic [7:0] e, input logic s);
    @(posedge clk);
    evt <= e;
    sym <= s;
    @(posedge clk);
    evt <= 8'h00;
    sym <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    stop_test;
  end
  initial begin
    resetn = 1'b0;
    evt = 8'h00;
    link = 2'b00;
    sym = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(5'h11, pvsir_pkg::LB_LED_RST);
    rd_chk(5'h13, 16'h0000);
    rd_chk(5'h15, 16'h0000);
    rd_chk(5'h1B, 16'h0000);
    rd_chk(5'h1F, 16'h0000);
    rd_chk(5'h1C, 16'h0000);
    chk("int_pin", 16'h0001, {15'h0000, int_pin});
    wr(5'h11, 16'hFFFF);
    rd_chk(5'h11, 16'hFFFE);
    chk("lb led", 16'h0003, {14'h0000, remote_loopback, led_test});
    wr(5'h11, 16'h0000);
    chk("lb led", 16'h0000, {14'h0000, remote_loopback, led_test});
    u_pvsir_mgmt_model.frame(pvsir_pkg::OP_WR, 5'h02, 5'h11, 16'hFFFF, rd);
    rd_chk(5'h11, 16'h0000);
    link <= 2'b10;
    wr(5'h13, 16'hFFFF);
    rd_chk(5'h13, 16'h0004);
    link <= 2'b01;
    rd_chk(5'h13, 16'h0002);
    for (int i = 0; i < 3; i++) pulse(8'h00, 1'b1);
    rd_chk(5'h15, 16'h0003);
    rd_chk(5'h15, 16'h0000);
    pulse(8'hFF, 1'b0);
    pin_chk(1'b1);
    rd_chk(5'h1B, 16'h00FF);
    rd_chk(5'h1B, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr(5'h1B, 16'h0100 << i);
      pulse(~(8'h01 << i), 1'b0);
      pin_chk(1'b1);
      pulse(8'h01 << i, 1'b0);
      chk("int_pin", 16'h0000, {15'h0000, int_pin});
      rd_chk(5'h1B, (16'h0100 << i) | 16'h00FF);
      chk("int_pin", 16'h0001, {15'h0000, int_pin});
      rd_chk(5'h1B, 16'h0100 << i);
    end
    wr(5'h1F, 16'h4000);
    rd_chk(5'h1F, 16'h4000);
    chk("int_pin", 16'h0000, {15'h0000, int_pin});
    pulse(8'h80, 1'b0);
    chk("int_pin", 16'h0001, {15'h0000, int_pin});
    // reset in mid-run brings the polarity, loopback and interrupt registers back to their reset values
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    pin_chk(1'b1);
    rd_chk(5'h1F, 16'h0000);
    rd_chk(5'h11, pvsir_pkg::LB_LED_RST);
    rd_chk(5'h1B, 16'h0000);
    stop_test;
  end
endmodule
`default_nettype wire
